// >>> design/stepper_status_pkg.sv
// Function
// - pwm rate from oscillator, divider and multiplier
// - rates defined for 8 to 32 MHz oscillators
// - config write while running ignored, error flagged
// - fixed 16-bit status word bit layout
// - float flag; motion commands leave float state
// - supply undervoltage flag low on lockout, reset
// - converter undervoltage event drives its flag low
// - overcurrent drives its flag low
// - stall on a bridge drives its flag low
// - bad or unknown command sets error flag
// - switch level bit shows inverted synchronised switch input
// - switch falling edge sets switch event flag
// - thermal state encoding normal to device shutdown
// - fault flags latched until status fetch
// - busy bit mirrors busy pin, low while executing
// - step clock flag high in step clock mode
// - direction bit one forward, zero reverse
// - motion phase encoding stopped to constant speed
// - status write ignored, error flagged
// - divider codes map to 1..7, 111 is 7
// - multiplier codes map to 0.625..2
// - status fetch returns status word to host
package stepper_status_pkg;

  // ----------------------------------------------------------------
  // command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_GET_STATUS = 8'hd0;
  localparam logic [7:0] CMD_RESET_DEVICE = 8'hc0;
  localparam logic [7:0] CMD_SOFT_FLOAT = 8'ha0;
  localparam logic [7:0] CMD_HARD_FLOAT = 8'ha8;
  localparam logic [2:0] OP_SET_PARAM = 3'h0;
  localparam logic [2:0] OP_MOTION_FIRST = 3'h2;
  localparam logic [2:0] OP_MOTION_LAST = 3'h5;
  localparam logic [2:0] OP_RESERVED = 3'h7;
  localparam logic [4:0] PARAM_CONFIG = 5'h18;
  localparam logic [4:0] PARAM_STATUS = 5'h19;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------------------------------
  // configuration and pwm rate
  // ----------------------------------------------------------------
  localparam logic [15:0] CONFIG_RESET = 16'h0c00;
  localparam int PWM_PRESCALE = 512;
  localparam int MULT_DEN = 8;
  // multiplier numerators over MULT_DEN, index is the code
  localparam logic [7:0][4:0] MULT_NUM = {5'h10, 5'h0e, 5'h0c, 5'h0a,
                                          5'h08, 5'h07, 5'h06, 5'h05};
  localparam logic [7:0][2:0] INT_DIV = {3'h7, 3'h7, 3'h6, 3'h5,
                                         3'h4, 3'h3, 3'h2, 3'h1};

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PHASE_STOPPED = 2'h0, PHASE_ACCEL = 2'h1, PHASE_DECEL = 2'h2, PHASE_CONST = 2'h3
  } motion_phase_t;

  typedef enum logic [1:0] {
    TH_NORMAL = 2'h0, TH_WARNING = 2'h1, TH_BRIDGE_OFF = 2'h2, TH_DEVICE_OFF = 2'h3
  } thermal_state_t;

  typedef enum logic [2:0] {
    PARSE_IDLE = 3'h1, PARSE_ARG_HI = 3'h2, PARSE_ARG_LO = 3'h4
  } parse_state_t;

  typedef struct packed {
    logic stall_b_n;
    logic stall_a_n;
    logic overcurrent_flag_n;
    thermal_state_t thermal_state;
    logic converter_undervoltage_flag_n;
    logic supply_undervoltage_flag_n;
    logic step_clock_mode_flag;
    logic bad_command;
    motion_phase_t motion_phase;
    logic direction;
    logic switch_closure_event;
    logic switch_level;
    logic busy_n;
    logic bridge_float_flag;
  } status_word_t;

  typedef struct packed {
    logic [2:0] pwm_int_code;
    logic [2:0] pwm_multiplier_code;
    logic [5:0] other_bits;
    logic [3:0] oscillator_select;
  } config_word_t;

endpackage : stepper_status_pkg

// >>> design/stepper_status_and_pwm_select.sv
`timescale 1ns/1ps
`default_nettype none
module stepper_status_and_pwm_select (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire logic switch_input_i,
  input wire logic supply_undervoltage_i,
  input wire logic converter_undervoltage_i,
  input wire logic overcurrent_i,
  input wire logic stall_a_i,
  input wire logic stall_b_i,
  input wire stepper_status_pkg::thermal_state_t thermal_level_i,
  input wire logic busy_n_i,
  input wire logic step_clock_mode_i,
  input wire logic direction_i,
  input wire stepper_status_pkg::motion_phase_t motion_phase_i,
  input wire logic bridges_floated_i,
  input wire logic fault_force_float_i,
  input wire logic cmd_reject_i,
  input wire logic cmd_arg_pending_i,
  output stepper_status_pkg::status_word_t driver_status_word_o,
  output stepper_status_pkg::config_word_t config_o,
  output logic pwm_tick_o,
  output logic cmd_strobe_o,
  output logic [7:0] cmd_byte_o
);

  // ----------------------------------------------------------------
  // link side, clocked by the host serial clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] rx_shift;
    logic [7:0] rx_byte;
    logic rx_toggle;
  } link_state_t;

  link_state_t l;
  link_state_t next_l;
  logic frame_open;
  logic [2:0] bit_now;
  logic [7:0] tx_byte_q;

  // the serial clock stops between frames, so the frame start is caught
  // by chip select rather than by a clock edge
  always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      frame_open <= 1'b0;
    end else begin
      frame_open <= 1'b1;
    end
  end

  assign bit_now = frame_open ? l.bit_cnt : 3'h0;

  always_comb begin
    next_l = l;
    next_l.rx_shift = {l.rx_shift[5:0], spi_mosi_i};
    next_l.bit_cnt = bit_now + 3'h1;
    if (bit_now == stepper_status_pkg::LAST_BIT) begin
      next_l.rx_byte = {l.rx_shift, spi_mosi_i};
      next_l.rx_toggle = ~l.rx_toggle;
    end
  end

  always_ff @(posedge spi_sck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // tx_byte_q is only changed while chip select is high, so it is
  // quasi-static for the whole frame
  assign spi_miso_o = tx_byte_q[stepper_status_pkg::LAST_BIT - bit_now];
  assign spi_miso_oe_o = ~spi_cs_n_i;

  // ----------------------------------------------------------------
  // core side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sw_meta;
    logic sw_sync;
    logic sw_prev;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    stepper_status_pkg::parse_state_t parse;
    logic arg_to_config;
    logic [7:0] arg_hi;
    stepper_status_pkg::config_word_t cfg;
    stepper_status_pkg::status_word_t stat;
    logic [7:0] tx_byte;
    logic [7:0] tx_lo;
    logic lo_pending;
    logic [15:0] pwm_acc;
    logic pwm_tick;
    logic cmd_strobe;
    logic [7:0] cmd_byte;
  } core_state_t;

  core_state_t s;
  core_state_t next_s;
  logic byte_evt;
  logic fetch;
  logic running;
  logic cfg_write_try;
  logic status_write_try;
  logic [7:0] rx;
  logic [2:0] op;
  logic err_now;
  logic motion_cmd;
  logic float_cmd;
  logic [15:0] pwm_limit;
  logic [15:0] pwm_sum;
  logic [4:0] mult;

  assign rx = l.rx_byte;
  assign op = rx[7:5];
  assign byte_evt = s.tog_sync != s.tog_seen;
  assign running = motion_phase_i != stepper_status_pkg::PHASE_STOPPED;
  assign fetch = byte_evt && !cmd_arg_pending_i && s.parse == stepper_status_pkg::PARSE_IDLE
                 && rx == stepper_status_pkg::CMD_GET_STATUS;
  assign status_write_try = byte_evt && !cmd_arg_pending_i
                            && s.parse == stepper_status_pkg::PARSE_IDLE
                            && op == stepper_status_pkg::OP_SET_PARAM
                            && rx[4:0] == stepper_status_pkg::PARAM_STATUS;
  assign cfg_write_try = byte_evt && s.parse == stepper_status_pkg::PARSE_ARG_LO
                         && s.arg_to_config;
  assign float_cmd = rx == stepper_status_pkg::CMD_SOFT_FLOAT
                     || rx == stepper_status_pkg::CMD_HARD_FLOAT;
  assign motion_cmd = byte_evt && !cmd_arg_pending_i && s.parse == stepper_status_pkg::PARSE_IDLE
                      && op >= stepper_status_pkg::OP_MOTION_FIRST
                      && op <= stepper_status_pkg::OP_MOTION_LAST && !float_cmd;
  assign err_now = cmd_reject_i || status_write_try || (cfg_write_try && running)
                   || (byte_evt && !cmd_arg_pending_i && s.parse == stepper_status_pkg::PARSE_IDLE
                       && op == stepper_status_pkg::OP_RESERVED);

  // a fractional accumulator gives the exact mean rate for every
  // multiplier while the clock stays the only timebase
  assign mult = stepper_status_pkg::MULT_NUM[s.cfg.pwm_multiplier_code];
  assign pwm_limit = 16'(stepper_status_pkg::PWM_PRESCALE * stepper_status_pkg::MULT_DEN)
                     * {13'h0, stepper_status_pkg::INT_DIV[s.cfg.pwm_int_code]};
  assign pwm_sum = s.pwm_acc + {11'h0, mult};

  always_comb begin
    next_s = s;
    next_s.sw_meta = switch_input_i;
    next_s.sw_sync = s.sw_meta;
    next_s.sw_prev = s.sw_sync;
    next_s.tog_meta = l.rx_toggle;
    next_s.tog_sync = s.tog_meta;
    next_s.tog_seen = s.tog_sync;
    next_s.cmd_strobe = byte_evt;
    if (byte_evt) begin
      next_s.cmd_byte = rx;
    end

    // pwm period tick
    if (pwm_sum >= pwm_limit) begin
      next_s.pwm_acc = pwm_sum - pwm_limit;
      next_s.pwm_tick = 1'b1;
    end else begin
      next_s.pwm_acc = pwm_sum;
      next_s.pwm_tick = 1'b0;
    end

    // live bits
    next_s.stat.step_clock_mode_flag = step_clock_mode_i;
    next_s.stat.direction = direction_i;
    next_s.stat.motion_phase = motion_phase_i;
    next_s.stat.switch_level = ~s.sw_sync;
    next_s.stat.busy_n = busy_n_i;

    // a fetch releases the latched bits, then live causes set them again
    if (fetch) begin
      next_s.stat.supply_undervoltage_flag_n = 1'b1;
      next_s.stat.converter_undervoltage_flag_n = 1'b1;
      next_s.stat.overcurrent_flag_n = 1'b1;
      next_s.stat.stall_a_n = 1'b1;
      next_s.stat.stall_b_n = 1'b1;
      next_s.stat.bad_command = 1'b0;
      next_s.stat.switch_closure_event = 1'b0;
      next_s.stat.thermal_state = thermal_level_i;
    end else if (thermal_level_i > s.stat.thermal_state) begin
      next_s.stat.thermal_state = thermal_level_i;
    end
    if (supply_undervoltage_i || (motion_cmd && rx == stepper_status_pkg::CMD_RESET_DEVICE)
        || (byte_evt && !cmd_arg_pending_i && s.parse == stepper_status_pkg::PARSE_IDLE
            && rx == stepper_status_pkg::CMD_RESET_DEVICE)) begin
      next_s.stat.supply_undervoltage_flag_n = 1'b0;
    end
    if (converter_undervoltage_i) begin
      next_s.stat.converter_undervoltage_flag_n = 1'b0;
    end
    if (overcurrent_i) begin
      next_s.stat.overcurrent_flag_n = 1'b0;
    end
    if (stall_a_i) begin
      next_s.stat.stall_a_n = 1'b0;
    end
    if (stall_b_i) begin
      next_s.stat.stall_b_n = 1'b0;
    end
    if (err_now) begin
      next_s.stat.bad_command = 1'b1;
    end
    if (s.sw_prev && !s.sw_sync) begin
      next_s.stat.switch_closure_event = 1'b1;
    end

    // bridge float: a forcing fault outranks a motion command
    if (fault_force_float_i || bridges_floated_i) begin
      next_s.stat.bridge_float_flag = 1'b1;
    end else if (motion_cmd) begin
      next_s.stat.bridge_float_flag = 1'b0;
    end

    // reply bytes; a new fetch aborts an unfinished reply
    if (byte_evt) begin
      if (fetch) begin
        next_s.tx_byte = s.stat[15:8];
        next_s.tx_lo = s.stat[7:0];
        next_s.lo_pending = 1'b1;
      end else if (s.lo_pending) begin
        next_s.tx_byte = s.tx_lo;
        next_s.lo_pending = 1'b0;
      end else begin
        next_s.tx_byte = 8'h00;
      end
    end

    // argument parser for the two parameters kept here
    unique case (s.parse)
      stepper_status_pkg::PARSE_IDLE: begin
        if (byte_evt && !cmd_arg_pending_i && op == stepper_status_pkg::OP_SET_PARAM
            && (rx[4:0] == stepper_status_pkg::PARAM_CONFIG || status_write_try)) begin
          next_s.arg_to_config = !status_write_try;
          next_s.parse = stepper_status_pkg::PARSE_ARG_HI;
        end
      end
      stepper_status_pkg::PARSE_ARG_HI: begin
        if (byte_evt) begin
          next_s.arg_hi = rx;
          next_s.parse = stepper_status_pkg::PARSE_ARG_LO;
        end
      end
      stepper_status_pkg::PARSE_ARG_LO: begin
        if (byte_evt) begin
          if (cfg_write_try && !running) begin
            next_s.cfg = {s.arg_hi, rx};
            next_s.pwm_acc = 16'h0000;
          end
          next_s.parse = stepper_status_pkg::PARSE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
      // switch chain starts at the open level so no false edge follows reset
      s.sw_meta <= 1'b1;
      s.sw_sync <= 1'b1;
      s.sw_prev <= 1'b1;
      s.parse <= stepper_status_pkg::PARSE_IDLE;
      s.cfg <= stepper_status_pkg::CONFIG_RESET;
      s.stat.stall_a_n <= 1'b1;
      s.stat.stall_b_n <= 1'b1;
      s.stat.overcurrent_flag_n <= 1'b1;
      s.stat.converter_undervoltage_flag_n <= 1'b1;
      s.stat.supply_undervoltage_flag_n <= 1'b0;
      s.stat.busy_n <= 1'b1;
      s.stat.bridge_float_flag <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // oscillator_select is only stored; the host keeps it true to the clock
  assign driver_status_word_o = s.stat;
  assign config_o = s.cfg;
  assign pwm_tick_o = s.pwm_tick;
  assign cmd_strobe_o = s.cmd_strobe;
  assign cmd_byte_o = s.cmd_byte;
  assign tx_byte_q = s.tx_byte;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  int gap;
  logic gap_valid;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap <= 0;
      gap_valid <= 1'b0;
    end else begin
      gap <= s.pwm_tick ? 1 : gap + 1;
      if (next_s.cfg != s.cfg) begin
        gap_valid <= 1'b0;
      end else if (s.pwm_tick) begin
        gap_valid <= 1'b1;
      end
    end
  end

  sequence s_fetch;
    byte_evt && fetch;
  endsequence

  sequence s_lo_turn;
    byte_evt && !fetch && s.lo_pending;
  endsequence

  property p_pwm_rate;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (s.pwm_tick && gap_valid) |-> (gap * int'(mult) > int'(pwm_limit) - int'(mult))
                                  && (gap * int'(mult) < int'(pwm_limit) + int'(mult));
  endproperty
  a_pwm_rate: assert property (p_pwm_rate) else $error("pwm period off");

  property p_cfg_locked;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (cfg_write_try && running) |=> s.stat.bad_command && $stable(s.cfg);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("config taken while running");

  property p_status_ro;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    status_write_try |=> s.stat.bad_command ##1 s.parse == stepper_status_pkg::PARSE_ARG_HI;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write not refused");

  property p_float_exit;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (motion_cmd && !fault_force_float_i && !bridges_floated_i) |=> !s.stat.bridge_float_flag;
  endproperty
  a_float_exit: assert property (p_float_exit) else $error("float flag kept");

  property p_fault_latch;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (overcurrent_i || stall_a_i) |=> (!s.stat.overcurrent_flag_n || !s.stat.stall_a_n)
                                     ##1 (fetch || !s.stat.overcurrent_flag_n
                                          || !s.stat.stall_a_n);
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault flag lost");

  property p_uv;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (supply_undervoltage_i || converter_undervoltage_i)
      |=> !(s.stat.supply_undervoltage_flag_n && s.stat.converter_undervoltage_flag_n);
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not flagged");

  property p_sw_edge;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    $fell(s.sw_sync) |=> s.stat.switch_closure_event && s.stat.switch_level;
  endproperty
  a_sw_edge: assert property (p_sw_edge) else $error("switch closure missed");

  property p_reply;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    s_fetch |=> s.tx_byte == $past(s.stat[15:8]) && s.tx_lo == $past(s.stat[7:0]);
  endproperty
  a_reply: assert property (p_reply) else $error("status reply wrong");

  property p_reply_lo;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    s_lo_turn |=> s.tx_byte == $past(s.tx_lo) && !s.lo_pending;
  endproperty
  a_reply_lo: assert property (p_reply_lo) else $error("second reply byte wrong");

  property p_release;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (s_fetch and !overcurrent_i && !cmd_reject_i && !status_write_try)
      |=> s.stat.overcurrent_flag_n && !s.stat.bad_command;
  endproperty
  a_release: assert property (p_release) else $error("flag not released");

  property p_mirror;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    1'b1 |=> s.stat.busy_n == $past(busy_n_i) && s.stat.motion_phase == $past(motion_phase_i)
             && s.stat.step_clock_mode_flag == $past(step_clock_mode_i)
             && s.stat.direction == $past(direction_i);
  endproperty
  a_mirror: assert property (p_mirror) else $error("live bit stale");

endmodule : stepper_status_and_pwm_select
`default_nettype wire

// >>> sim/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host on the serial command port
// ----------------------------------------------------------------
module spi_host_model (
  input wire logic link_clk_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o
);
  initial begin
    sck_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // sck idles high and only toggles inside a frame; after the last bit
  // the data line shows the inverse so a stale bit is never read as valid
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(posedge link_clk_i);
    cs_n_o <= 1'b0;
    mosi_o <= tx[7];
    // data moves on the falling half so it never races the rising sample
    for (int i = 7; i >= 0; i--) begin
      @(negedge link_clk_i);
      sck_o <= 1'b0;
      mosi_o <= tx[i];
      @(posedge link_clk_i);
      rx[i] = miso_i;
      sck_o <= 1'b1;
    end
    @(posedge link_clk_i);
    cs_n_o <= 1'b1;
    mosi_o <= ~tx[0];
    // long cs gap so the reply byte settles in the core domain
    repeat (8) @(posedge link_clk_i);
  endtask : xfer

  // the word is sent as given, oscillator select included; nothing checks it against the clock
  task automatic cfg_write(input logic [15:0] w);
    logic [7:0] rx;
    xfer({stepper_status_pkg::OP_SET_PARAM, stepper_status_pkg::PARAM_CONFIG}, rx);
    xfer(w[15:8], rx);
    xfer(w[7:0], rx);
  endtask : cfg_write
endmodule : spi_host_model
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk_i = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b_i = 1'b1;
  logic sck, cs_n, mosi, miso, miso_oe, miso_line;
  logic sw = 1'b1;
  logic [4:0] cause = 5'h00;
  stepper_status_pkg::thermal_state_t thermal = stepper_status_pkg::TH_NORMAL;
  stepper_status_pkg::motion_phase_t phase = stepper_status_pkg::PHASE_STOPPED;
  logic busy_n = 1'b1, step_clock_pin = 1'b0, dir = 1'b0, floated = 1'b0, frc = 1'b0, rej = 1'b0;
  stepper_status_pkg::status_word_t st;
  stepper_status_pkg::config_word_t cfg;
  logic tick_o, strobe;
  logic [7:0] cbyte, rx;
  logic [15:0] w, cfg_exp;
  logic [31:0] r;
  logic [2:0] ic;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h8170;
  int n, lo;
  int pos [5] = '{9, 10, 13, 14, 15};

  always #10 core_clk_i = ~core_clk_i;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  assign miso_line = miso_oe ? miso : 1'b1;

  stepper_status_and_pwm_select stepper_status_and_pwm_select_i (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .switch_input_i(sw),
    .supply_undervoltage_i(cause[0]), .converter_undervoltage_i(cause[1]),
    .overcurrent_i(cause[2]), .stall_a_i(cause[3]), .stall_b_i(cause[4]),
    .thermal_level_i(thermal), .busy_n_i(busy_n), .step_clock_mode_i(step_clock_pin),
    .direction_i(dir), .motion_phase_i(phase), .bridges_floated_i(floated),
    .fault_force_float_i(frc), .cmd_reject_i(rej), .cmd_arg_pending_i(1'b0),
    .driver_status_word_o(st), .config_o(cfg), .pwm_tick_o(tick_o),
    .cmd_strobe_o(strobe), .cmd_byte_o(cbyte)
  );

  spi_host_model spi_host_model_i (
    .link_clk_i(link_clk), .miso_i(miso_line), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask : tick

  task automatic send(input logic [7:0] b, output logic [7:0] rb);
    spi_host_model_i.xfer(b, rb);
    tick(8);
  endtask : send

  task automatic fetch(output logic [15:0] fw);
    logic [7:0] d;
    send(stepper_status_pkg::CMD_GET_STATUS, d);
    send(stepper_status_pkg::CMD_NOP, fw[15:8]);
    send(stepper_status_pkg::CMD_NOP, fw[7:0]);
  endtask : fetch

  // counts core cycles up to the next pwm tick, bounded
  task automatic wait_tick(output int k);
    k = 0;
    do begin
      tick(1);
      k++;
    end while (tick_o !== 1'b1 && k < 8000);
  endtask : wait_tick

  function automatic int divisor(input logic [2:0] c);
    return (c == 3'h7) ? 7 : c + 1;
  endfunction : divisor

  function automatic int mult_num(input logic [2:0] c);
    return (c < 3'h4) ? c + 5 : 2 * c + 2;
  endfunction : mult_num

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    // a real falling edge so the link-side flops see the reset too
    rst_b_i <= 1'b0;
    tick(3);
    chk("reset word", 16'he403, st);
    chk("reset config", stepper_status_pkg::CONFIG_RESET, cfg);
    @(posedge core_clk_i);
    @(posedge core_clk_i);
    @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    tick(3);
    fetch(w);
    chk("fetched supply_undervoltage_flag_n", 16'h0, w[9]);
    tick(4);
    chk("supply_undervoltage_flag_n released", 16'h1, st[9]);
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk_i);
      cause <= 5'h01 << i;
      @(posedge core_clk_i);
      cause <= 5'h00;
      tick(4);
      chk("latched flag", 16'h0, st[pos[i]]);
      fetch(w);
      chk("fetched flag", 16'h0, w[pos[i]]);
      tick(4);
      chk("released flag", 16'h1, st[pos[i]]);
    end
    // a cause still present wins over the fetch release
    @(posedge core_clk_i);
    cause <= 5'h08;
    fetch(w);
    chk("held stall", 16'h0, st.stall_a_n);
    @(posedge core_clk_i);
    cause <= 5'h00;
    fetch(w);
    for (int t = 1; t < 4; t++) begin
      @(posedge core_clk_i);
      thermal <= stepper_status_pkg::thermal_state_t'(t[1:0]);
      @(posedge core_clk_i);
      thermal <= stepper_status_pkg::TH_NORMAL;
      tick(4);
      chk("thermal latched", t[1:0], st.thermal_state);
      fetch(w);
      tick(4);
      chk("thermal released", 16'h0, st.thermal_state);
    end
    @(posedge core_clk_i);
    sw <= 1'b0;
    tick(5);
    chk("switch closed", 16'h3, {st.switch_closure_event, st.switch_level});
    @(posedge core_clk_i);
    sw <= 1'b1;
    tick(5);
    chk("switch open", 16'h2, {st.switch_closure_event, st.switch_level});
    fetch(w);
    tick(4);
    chk("switch event", 16'h0, st.switch_closure_event);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      @(posedge core_clk_i);
      busy_n <= r[0];
      step_clock_pin <= r[1];
      dir <= r[2];
      phase <= stepper_status_pkg::motion_phase_t'(i[1:0]);
      tick(3);
      chk("live bits", {r[1], i[1:0], r[2], r[0]}, {st[8], st[6:5], st[4], st[1]});
    end
    @(posedge core_clk_i);
    busy_n <= 1'b1;
    phase <= stepper_status_pkg::PHASE_STOPPED;
    @(posedge core_clk_i);
    floated <= 1'b1;
    @(posedge core_clk_i);
    floated <= 1'b0;
    send(8'hb8, rx);
    chk("float left", 16'h0, st.bridge_float_flag);
    chk("command byte", 16'h00b8, cbyte);
    @(posedge core_clk_i);
    frc <= 1'b1;
    send(8'hb8, rx);
    chk("float forced", 16'h1, st.bridge_float_flag);
    @(posedge core_clk_i);
    frc <= 1'b0;
    cfg_exp = cfg;
    // refused requests: status write, reserved opcode, outside reject, running config
    for (int k = 0; k < 4; k++) begin
      w = $random(seed);
      case (k)
        0: begin
          send({stepper_status_pkg::OP_SET_PARAM, stepper_status_pkg::PARAM_STATUS}, rx);
          send(w[15:8], rx);
          send(w[7:0], rx);
          chk("status kept", 16'h7, st[15:13]);
        end
        1: send({stepper_status_pkg::OP_RESERVED, 5'h00}, rx);
        2: begin
          @(posedge core_clk_i);
          rej <= 1'b1;
          @(posedge core_clk_i);
          rej <= 1'b0;
        end
        default: begin
          @(posedge core_clk_i);
          phase <= stepper_status_pkg::PHASE_CONST;
          spi_host_model_i.cfg_write(w);
        end
      endcase
      tick(6);
      chk("bad command", 16'h1, st.bad_command);
      chk("config kept", cfg_exp, cfg);
      @(posedge core_clk_i);
      phase <= stepper_status_pkg::PHASE_STOPPED;
      fetch(w);
      tick(4);
      chk("bad released", 16'h0, st.bad_command);
    end
    for (int m = 0; m < 8; m++) begin
      r = $random(seed);
      ic = (m == 7) ? 3'h7 : {1'b0, r[1:0]};
      cfg_exp = {ic, m[2:0], 6'h00, r[7:4]};
      spi_host_model_i.cfg_write(cfg_exp);
      tick(8);
      chk("config", cfg_exp, cfg);
      lo = 4096 * divisor(ic) / mult_num(m[2:0]);
      wait_tick(n);
      wait_tick(n);
      comparisons++;
      if (n < lo || n > lo + 1) begin
        $display("wrong value pwm interval expected %0d seen %0d", lo, n);
        err_count++;
      end
    end
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
